// >>> core/plrc_pkg.sv
// Shared constants, register map and types of the loop reset, lock and feedback control block
package plrc_pkg;

  // Bus and datapath widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DIV_W = 8;
  localparam int TRIM_W = 4;
  localparam int MODE_W = 3;
  localparam int NUM_OUT = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_MDIV = 8'h08;
  localparam logic [ADDR_W-1:0] REG_NDIV = 8'h0c;
  localparam logic [ADDR_W-1:0] REG_C0DIV = 8'h10;
  localparam logic [ADDR_W-1:0] REG_C1DIV = 8'h14;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h18;

  // Field positions
  localparam int CTRL_SELF_RST_BIT = 0;
  localparam int CTRL_NONDED_BIT = 1;
  localparam int CTRL_COMP_SEL_BIT = 2;
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_LOST_BIT = 1;
  localparam int STAT_REJECT_BIT = 2;
  localparam int STAT_FRAC_BIT = 3;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_TRIM_LSB = 8;

  // Reset values and divider limits
  localparam logic [DIV_W-1:0] DIV_RESET = 8'h04;
  localparam logic [DIV_W-1:0] DIV_MIN = 8'h01;
  localparam logic [DIV_W-1:0] DIV_MAX = 8'hff;
  localparam logic signed [TRIM_W-1:0] TRIM_NOMINAL = 4'sh0;
  localparam logic signed [TRIM_W-1:0] TRIM_MAX = 4'sh7;
  localparam logic signed [TRIM_W-1:0] TRIM_MIN = 4'sh8;

  // Timing: self-reset pulse is a least time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 40;
  localparam int SELF_RST_NS = 1000;
  localparam int SELF_RST_CYCLES = (SELF_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] SELF_RST_LAST = 6'(SELF_RST_CYCLES - 1);
  localparam logic [3:0] LOCK_GOOD_COUNT = 4'h8;
  localparam logic [DIV_W-1:0] LOCK_WIN = 8'h02;

  // Feedback modes as software writes them
  typedef enum logic [MODE_W-1:0] {
    FB_DIRECT = 3'h0,
    FB_LVDS = 3'h1,
    FB_SOURCE_SYNC = 3'h2,
    FB_NORMAL = 3'h3,
    FB_ZERO_DELAY = 3'h4,
    FB_EXTERNAL = 3'h5
  } plrc_fb_mode_t;

  // Loop control states
  typedef enum logic [2:0] {
    ST_RESET,
    ST_RESYNC,
    ST_ACQUIRE,
    ST_LOCKED,
    ST_SELF_RESET
  } plrc_state_t;

endpackage

// >>> core/plrc_divider.sv
// Loop counter: divides the reference clock, with tick and level outputs; level is high for the first half of each count, rounded up
`timescale 1ns/1ns
module plrc_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic [plrc_pkg::DIV_W-1:0] divisor,
  // Outputs
  output logic tick,
  output logic level
);

  logic [plrc_pkg::DIV_W-1:0] count;
  logic [plrc_pkg::DIV_W-1:0] lastCount;
  logic [plrc_pkg::DIV_W:0] halfCount;
  logic [plrc_pkg::DIV_W-1:0] next_count;

  // A zero divisor ends the count at zero as one does, so the counter never runs away
  assign lastCount = (divisor == '0) ? '0 : divisor - plrc_pkg::DIV_MIN;
  assign halfCount = ({1'b0, divisor} + 9'h001) >> 1;
  assign tick = (count == lastCount);
  assign level = ({1'b0, count} < halfCount);
  assign next_count = (clear || tick) ? '0 : count + plrc_pkg::DIV_MIN;

  // Counter state
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // plrc_divider

// >>> core/plrc_lock_detect.sv
// Phase and frequency comparison of feedback ticks against reference ticks
`timescale 1ns/1ns
module plrc_lock_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Comparison inputs
  input wire logic enable,
  input wire logic refTick,
  input wire logic fbTick,
  input wire logic [plrc_pkg::DIV_W-1:0] period,
  // Verdict pulses, one per reference interval
  output logic good,
  output logic bad,
  output logic fbFast,
  output logic fbSlow
);

  logic valid;
  logic [1:0] fbCount;
  logic [plrc_pkg::DIV_W-1:0] sinceRef;
  logic [plrc_pkg::DIV_W-1:0] lag;
  logic phaseOk;
  logic match;

  // Lag close to zero or close to one full period both count as aligned
  assign phaseOk = (lag <= plrc_pkg::LOCK_WIN) ||
                   ({1'b0, lag} + {1'b0, plrc_pkg::LOCK_WIN} >= {1'b0, period});
  assign match = (fbCount == 2'h1) && phaseOk;

  // Interval bookkeeping; a feedback tick on the reference tick opens the new interval
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid <= 1'b0;
      fbCount <= 2'h0;
      sinceRef <= '0;
      lag <= '0;
    end else if (!enable || refTick) begin
      valid <= enable;
      fbCount <= (enable && fbTick) ? 2'h1 : 2'h0;
      sinceRef <= '0;
      lag <= '0;
    end else begin
      sinceRef <= (sinceRef == plrc_pkg::DIV_MAX) ? sinceRef : sinceRef + plrc_pkg::DIV_MIN;
      fbCount <= (fbTick && fbCount != 2'h3) ? fbCount + 2'h1 : fbCount;
      lag <= (fbTick && fbCount == 2'h0) ? sinceRef + plrc_pkg::DIV_MIN : lag;
    end
  end

  // Verdicts are given only for intervals that were watched from their start
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      good <= 1'b0;
      bad <= 1'b0;
      fbFast <= 1'b0;
      fbSlow <= 1'b0;
    end else begin
      good <= enable && refTick && valid && match;
      bad <= enable && refTick && valid && !match;
      fbFast <= enable && refTick && valid && (fbCount > 2'h1);
      fbSlow <= enable && refTick && valid && (fbCount == 2'h0);
    end
  end

endmodule // plrc_lock_detect

// >>> core/plrc_pll_ctrl.sv
// Top of the loop control block: reset sequencing, lock status, feedback selection, registers
`timescale 1ns/1ns
module plrc_pll_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [plrc_pkg::ADDR_W-1:0] regAddr,
  input wire logic [plrc_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [plrc_pkg::DATA_W-1:0] regRdData,
  // Loop control from core logic
  input wire logic pllReset,
  input wire logic fractionalStrap,
  // Feedback pins
  input wire logic fbIn,
  output logic fbOut,
  output logic fbOutEn,
  // Generated clocks
  output logic [plrc_pkg::NUM_OUT-1:0] outClk,
  output logic lvdsCaptureClk,
  output logic externalClockOut,
  output logic [plrc_pkg::NUM_OUT-1:0] compensatedMask,
  // Status
  output logic locked
);

  plrc_pkg::plrc_state_t state;
  plrc_pkg::plrc_state_t next_state;
  plrc_pkg::plrc_fb_mode_t fbMode;

  // Configuration registers
  logic selfResetEn;
  logic nondedicated;
  logic compSel;
  logic [plrc_pkg::DIV_W-1:0] mDivide;
  logic [plrc_pkg::DIV_W-1:0] nDivide;
  logic [plrc_pkg::DIV_W-1:0] c0Divide;
  logic [plrc_pkg::DIV_W-1:0] c1Divide;

  // Status and loop state
  logic lockLost;
  logic modeRejected;
  logic fractional;
  logic strapTaken;
  logic signed [plrc_pkg::TRIM_W-1:0] trim;
  logic realign;
  logic [3:0] goodCount;
  logic [5:0] selfRstCount;
  logic fbInPrev;

  // Bus decode
  logic selCtrl;
  logic selMode;
  logic selMdiv;
  logic selNdiv;
  logic selC0;
  logic selC1;
  logic selStatus;
  logic [plrc_pkg::DATA_W-1:0] readMux;

  assign selCtrl = (regAddr == plrc_pkg::REG_CTRL);
  assign selMode = (regAddr == plrc_pkg::REG_MODE);
  assign selMdiv = (regAddr == plrc_pkg::REG_MDIV);
  assign selNdiv = (regAddr == plrc_pkg::REG_NDIV);
  assign selC0 = (regAddr == plrc_pkg::REG_C0DIV);
  assign selC1 = (regAddr == plrc_pkg::REG_C1DIV);
  assign selStatus = (regAddr == plrc_pkg::REG_STATUS);

  // Mode write screening; the strap is read directly until it has been captured
  logic fracNow;
  logic [plrc_pkg::MODE_W-1:0] modeReq;
  logic modeLegal;
  logic modeWrite;
  logic modeAccept;

  assign fracNow = strapTaken ? fractional : fractionalStrap;
  assign modeReq = regWrData[plrc_pkg::MODE_W-1:0];
  assign modeLegal = (modeReq <= plrc_pkg::FB_EXTERNAL);
  assign modeWrite = regWrite && selMode;
  assign modeAccept = modeWrite && modeLegal &&
                      (!fracNow || modeReq == plrc_pkg::FB_DIRECT);

  // Loop state decode
  logic inReset;
  logic acquiring;
  logic lossEvent;
  logic compMode;
  logic extFeedback;

  assign inReset = (state == plrc_pkg::ST_RESET) || (state == plrc_pkg::ST_SELF_RESET);
  assign acquiring = (state == plrc_pkg::ST_ACQUIRE) || (state == plrc_pkg::ST_LOCKED);
  assign compMode = (fbMode == plrc_pkg::FB_NORMAL) || (fbMode == plrc_pkg::FB_SOURCE_SYNC);
  assign extFeedback = (fbMode == plrc_pkg::FB_ZERO_DELAY) || (fbMode == plrc_pkg::FB_EXTERNAL);

  // Effective multiply divisor, pulled by the trim and held inside the counter range
  logic signed [plrc_pkg::DIV_W+1:0] mSum;
  logic [plrc_pkg::DIV_W-1:0] mEffective;

  assign mSum = $signed({2'b00, mDivide}) +
                $signed({{(plrc_pkg::DIV_W + 2 - plrc_pkg::TRIM_W){trim[plrc_pkg::TRIM_W-1]}},
                         trim});
  assign mEffective = (mSum < $signed({2'b00, plrc_pkg::DIV_MIN})) ? plrc_pkg::DIV_MIN :
                      (mSum > $signed({2'b00, plrc_pkg::DIV_MAX})) ? plrc_pkg::DIV_MAX :
                      mSum[plrc_pkg::DIV_W-1:0];

  // Counters: all held clear in reset; multiply and output counters also clear on realignment
  logic refTick;
  logic mTick;
  logic mLevel;
  logic [plrc_pkg::NUM_OUT-1:0] cTick;
  logic [plrc_pkg::NUM_OUT-1:0] cLevel;
  logic alignNow;
  logic loopClear;

  assign alignNow = refTick && ((state == plrc_pkg::ST_RESYNC) || realign);
  assign loopClear = inReset || alignNow;

  plrc_divider uRefDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(inReset),
    .divisor(nDivide),
    .tick(refTick),
    .level()
  );

  plrc_divider uMulDiv (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(loopClear),
    .divisor(mEffective),
    .tick(mTick),
    .level(mLevel)
  );

  plrc_divider uOut0Div (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(loopClear),
    .divisor(c0Divide),
    .tick(cTick[0]),
    .level(cLevel[0])
  );

  plrc_divider uOut1Div (
    .clk(clk),
    .sys_rst(sys_rst),
    .clear(loopClear),
    .divisor(c1Divide),
    .tick(cTick[1]),
    .level(cLevel[1])
  );

  // Feedback source selection
  logic fbInRise;
  logic fbTick;

  assign fbInRise = fbIn && !fbInPrev;
  assign fbTick = extFeedback ? fbInRise :
                  (compMode && nondedicated) ? cTick[compSel] :
                  mTick;

  logic lockGood;
  logic lockBad;
  logic fbFast;
  logic fbSlow;

  plrc_lock_detect uLockDet (
    .clk(clk),
    .sys_rst(sys_rst),
    .enable(acquiring),
    .refTick(refTick),
    .fbTick(fbTick),
    .period(nDivide),
    .good(lockGood),
    .bad(lockBad),
    .fbFast(fbFast),
    .fbSlow(fbSlow)
  );

  assign lossEvent = (state == plrc_pkg::ST_LOCKED) && lockBad;

  // Loop sequencing; an external reset outranks every other condition
  always_comb begin
    next_state = state;
    case (state)
      plrc_pkg::ST_RESET: begin
        if (!pllReset) begin
          next_state = plrc_pkg::ST_RESYNC;
        end
      end
      plrc_pkg::ST_RESYNC: begin
        if (refTick) begin
          next_state = plrc_pkg::ST_ACQUIRE;
        end
      end
      plrc_pkg::ST_ACQUIRE: begin
        if (lockGood && goodCount == plrc_pkg::LOCK_GOOD_COUNT - 4'h1) begin
          next_state = plrc_pkg::ST_LOCKED;
        end
      end
      plrc_pkg::ST_LOCKED: begin
        if (lockBad) begin
          next_state = selfResetEn ? plrc_pkg::ST_SELF_RESET : plrc_pkg::ST_ACQUIRE;
        end
      end
      plrc_pkg::ST_SELF_RESET: begin
        if (selfRstCount == plrc_pkg::SELF_RST_LAST) begin
          next_state = plrc_pkg::ST_RESYNC;
        end
      end
      default: begin
        next_state = plrc_pkg::ST_RESET;
      end
    endcase
    if (pllReset) begin
      next_state = plrc_pkg::ST_RESET;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= plrc_pkg::ST_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Lock qualification and self-reset timing
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      goodCount <= 4'h0;
      selfRstCount <= 6'h00;
    end else begin
      goodCount <= (state != plrc_pkg::ST_ACQUIRE || lockBad) ? 4'h0 :
                   lockGood ? goodCount + 4'h1 : goodCount;
      selfRstCount <= (state == plrc_pkg::ST_SELF_RESET) ? selfRstCount + 6'h01 : 6'h00;
    end
  end

  // Oscillator pull: frequency errors move the trim, pure phase errors request a realignment
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trim <= plrc_pkg::TRIM_NOMINAL;
      realign <= 1'b0;
    end else if (inReset) begin
      trim <= plrc_pkg::TRIM_NOMINAL;
      realign <= 1'b0;
    end else begin
      if (fbFast && trim != plrc_pkg::TRIM_MAX) begin
        trim <= trim + 4'sh1;
      end else if (fbSlow && trim != plrc_pkg::TRIM_MIN) begin
        trim <= trim - 4'sh1;
      end
      realign <= refTick ? 1'b0 : (realign || (lockBad && !fbFast && !fbSlow));
    end
  end

  // Strap capture after release, and the edge memory for the external feedback input
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapTaken <= 1'b0;
      fractional <= 1'b0;
      fbInPrev <= 1'b0;
    end else begin
      strapTaken <= 1'b1;
      fractional <= strapTaken ? fractional : fractionalStrap;
      fbInPrev <= fbIn;
    end
  end

  // Writable configuration
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selfResetEn <= 1'b0;
      nondedicated <= 1'b0;
      compSel <= 1'b0;
      fbMode <= plrc_pkg::FB_DIRECT;
      mDivide <= plrc_pkg::DIV_RESET;
      nDivide <= plrc_pkg::DIV_RESET;
      c0Divide <= plrc_pkg::DIV_RESET;
      c1Divide <= plrc_pkg::DIV_RESET;
    end else begin
      if (regWrite && selCtrl) begin
        selfResetEn <= regWrData[plrc_pkg::CTRL_SELF_RST_BIT];
        nondedicated <= regWrData[plrc_pkg::CTRL_NONDED_BIT];
        compSel <= regWrData[plrc_pkg::CTRL_COMP_SEL_BIT];
      end
      if (modeAccept) begin
        fbMode <= plrc_pkg::plrc_fb_mode_t'(modeReq);
      end
      mDivide <= (regWrite && selMdiv) ? regWrData[plrc_pkg::DIV_W-1:0] : mDivide;
      nDivide <= (regWrite && selNdiv) ? regWrData[plrc_pkg::DIV_W-1:0] : nDivide;
      c0Divide <= (regWrite && selC0) ? regWrData[plrc_pkg::DIV_W-1:0] : c0Divide;
      c1Divide <= (regWrite && selC1) ? regWrData[plrc_pkg::DIV_W-1:0] : c1Divide;
    end
  end

  // Sticky status; a new event in the clearing cycle survives the clear
  logic clrLost;
  logic clrReject;
  logic modeRefused;

  assign clrLost = regWrite && selStatus && regWrData[plrc_pkg::STAT_LOST_BIT];
  assign clrReject = regWrite && selStatus && regWrData[plrc_pkg::STAT_REJECT_BIT];
  assign modeRefused = modeWrite && !modeAccept;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockLost <= 1'b0;
      modeRejected <= 1'b0;
    end else begin
      lockLost <= lossEvent || (lockLost && !clrLost);
      modeRejected <= modeRefused || (modeRejected && !clrReject);
    end
  end

  // Read selection; unmapped offsets read as zero
  always_comb begin
    readMux = '0;
    if (selCtrl) begin
      readMux[plrc_pkg::CTRL_SELF_RST_BIT] = selfResetEn;
      readMux[plrc_pkg::CTRL_NONDED_BIT] = nondedicated;
      readMux[plrc_pkg::CTRL_COMP_SEL_BIT] = compSel;
    end else if (selMode) begin
      readMux[plrc_pkg::MODE_W-1:0] = fbMode;
    end else if (selMdiv) begin
      readMux[plrc_pkg::DIV_W-1:0] = mDivide;
    end else if (selNdiv) begin
      readMux[plrc_pkg::DIV_W-1:0] = nDivide;
    end else if (selC0) begin
      readMux[plrc_pkg::DIV_W-1:0] = c0Divide;
    end else if (selC1) begin
      readMux[plrc_pkg::DIV_W-1:0] = c1Divide;
    end else if (selStatus) begin
      readMux[plrc_pkg::STAT_LOCKED_BIT] = locked;
      readMux[plrc_pkg::STAT_LOST_BIT] = lockLost;
      readMux[plrc_pkg::STAT_REJECT_BIT] = modeRejected;
      readMux[plrc_pkg::STAT_FRAC_BIT] = fractional;
      readMux[plrc_pkg::STAT_STATE_LSB +: 3] = state;
      readMux[plrc_pkg::STAT_TRIM_LSB +: plrc_pkg::TRIM_W] = trim;
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRead ? readMux : '0;
    end
  end

  // Clock outputs; the fractional variant keeps both output counters but drives only the first output clock
  logic [plrc_pkg::NUM_OUT-1:0] next_outClk;
  logic [plrc_pkg::NUM_OUT-1:0] next_compMask;

  assign next_outClk = inReset ? '0 : {cLevel[1] && !fractional, cLevel[0]};
  assign next_compMask = compMode ? (compSel ? 2'h2 : 2'h1) : 2'h0;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      outClk <= '0;
      lvdsCaptureClk <= 1'b0;
      externalClockOut <= 1'b0;
      compensatedMask <= '0;
      locked <= 1'b0;
    end else begin
      outClk <= next_outClk;
      lvdsCaptureClk <= !inReset && fbMode == plrc_pkg::FB_LVDS && !cLevel[1];
      externalClockOut <= !inReset && fbMode != plrc_pkg::FB_EXTERNAL && cLevel[0];
      compensatedMask <= next_compMask;
      locked <= (next_state == plrc_pkg::ST_LOCKED);
    end
  end

  // Feedback pin drive: multiply counter in external mode, output copy in zero delay mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fbOut <= 1'b0;
      fbOutEn <= 1'b0;
    end else begin
      fbOut <= !inReset && ((fbMode == plrc_pkg::FB_EXTERNAL) ? mLevel : cLevel[0]);
      fbOutEn <= extFeedback;
    end
  end

endmodule // plrc_pll_ctrl

// >>> testbench/plrc_pll_ctrl_properties.sv
// Port-level property checker for the loop control block
`timescale 1ns/1ns
module plrc_pll_ctrl_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [31:0] regRdData,
  // Loop pins
  input wire logic pllReset,
  input wire logic fractionalStrap,
  input wire logic fbIn,
  input wire logic fbOut,
  input wire logic fbOutEn,
  input wire logic [1:0] outClk,
  input wire logic lvdsCaptureClk,
  input wire logic externalClockOut,
  input wire logic [1:0] compensatedMask,
  input wire logic locked
);
  logic [2:0] mode;
  logic [2:0] prevMode;
  logic selfEn;
  logic [3:0] sinceRst;
  wire modeOk = regWrData[2:0] <= 3'h5 && !(fractionalStrap && regWrData[2:0] != 3'h0);
  // Shadow of mode and self-reset enable; refused mode writes leave the shadow alone
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= 3'h0;
      prevMode <= 3'h0;
      selfEn <= 1'b0;
      sinceRst <= 4'h0;
    end else begin
      prevMode <= mode;
      if (regWrite && regAddr == plrc_pkg::REG_MODE && modeOk) begin
        mode <= regWrData[2:0];
      end
      if (regWrite && regAddr == plrc_pkg::REG_CTRL) begin
        selfEn <= regWrData[0];
      end
      // Saturates so a long lock never wraps back to a small count
      if (pllReset) begin
        sinceRst <= 4'h0;
      end else if (sinceRst != 4'hf) begin
        sinceRst <= sinceRst + 4'h1;
      end
    end
  end
  // Outputs may lag a mode write by a cycle, so judge only a settled mode
  wire steady = mode == prevMode;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_reset_drops_lock: assert property (pllReset |=> !locked)
    else $error("lock kept during loop reset");
  a_reset_quiet_clk: assert property (pllReset |-> ##2 (outClk == 2'h0 && !fbOut &&
    !lvdsCaptureClk && !externalClockOut)) else $error("output clocks run during loop reset");
  a_lock_not_early: assert property (locked |-> sinceRst > 4'h8)
    else $error("lock reported too soon after reset");
  a_status_lock_bit: assert property (regRead && regAddr == plrc_pkg::REG_STATUS
    |=> regRdData[0] == $past(locked)) else $error("status lock bit differs");
  a_self_reset_hold: assert property ($fell(locked) && selfEn |-> ##24 !locked)
    else $error("self reset too short");
  a_fb_pin_mode: assert property (steady |-> fbOutEn == (mode == 3'h4 || mode == 3'h5))
    else $error("feedback pin enable wrong for mode");
  a_direct_no_comp: assert property (steady && mode == 3'h0
    |-> compensatedMask == 2'h0 && !lvdsCaptureClk) else $error("direct mode compensates");
  a_one_comp_out: assert property (steady && (mode == 3'h2 || mode == 3'h3)
    |-> $onehot(compensatedMask)) else $error("compensated outputs not one");
  a_lvds_inverted: assert property (locked && steady && mode == 3'h1
    |-> lvdsCaptureClk != outClk[1]) else $error("capture clock not inverted");
  a_ext_pin_taken: assert property (steady && mode == 3'h5 |-> !externalClockOut)
    else $error("clock output busy as feedback pin");
  a_frac_one_out: assert property (fractionalStrap |-> !outClk[1])
    else $error("second output runs in fractional variant");
  c_lock_gained: cover property ($rose(locked));
  c_self_reset: cover property ($fell(locked) && selfEn);
  c_lvds_locked: cover property (locked && mode == 3'h1);
endmodule // plrc_pll_ctrl_properties

bind plrc_pll_ctrl plrc_pll_ctrl_properties chk (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
  .regRdData(regRdData), .pllReset(pllReset), .fractionalStrap(fractionalStrap), .fbIn(fbIn),
  .fbOut(fbOut), .fbOutEn(fbOutEn), .outClk(outClk), .lvdsCaptureClk(lvdsCaptureClk),
  .externalClockOut(externalClockOut), .compensatedMask(compensatedMask), .locked(locked));

// >>> testbench/plrc_core_model.sv
// Core-logic model: drives loop reset, closes the feedback trace, idles downstream logic
`timescale 1ns/1ns
module plrc_core_model (
  // Clock
  input wire logic clk,
  // Commands from the bench
  input wire logic holdReset,
  input wire logic pulseOnLoss,
  // Loop pins
  input wire logic locked,
  input wire logic fbOut,
  input wire logic fbOutEn,
  output logic pllReset,
  output logic fbIn,
  output logic downstreamRun
);
  logic wasLocked = 1'b0;
  logic [1:0] pulseLeft = 2'h0;
  // Reset is held on command and pulsed after each loss of lock to restore phase
  always @(posedge clk) begin
    wasLocked <= locked;
    if (pulseOnLoss && wasLocked && !locked) begin
      pulseLeft <= 2'h2;
    end else if (pulseLeft != 2'h0) begin
      pulseLeft <= pulseLeft - 2'h1;
    end
    pllReset <= holdReset || pulseLeft != 2'h0;
  end
  // Trace closes the loop only while driven; a pull-down holds it low otherwise
  assign fbIn = fbOutEn ? fbOut : 1'b0;
  // Downstream logic stops the moment lock drops
  assign downstreamRun = locked;
endmodule // plrc_core_model

// >>> testbench/plrc_pll_ctrl_tb.sv
// Self-checking bench for the loop control block
`timescale 1ns/1ns
module plrc_pll_ctrl_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr;
  logic [31:0] regWrData, regRdData;
  logic regWrite, regRead, fractionalStrap, holdReset, pulseOnLoss, pllReset, fbIn;
  logic fbOut, fbOutEn, lvdsCaptureClk, externalClockOut, locked, downstreamRun, rdPend;
  logic [1:0] outClk, compensatedMask;
  logic [31:0] expQ[$];
  logic [31:0] mskQ[$];
  logic [7:0] addrs[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
  logic [31:0] vals[7] = '{0, 0, 4, 4, 4, 4, 0};
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // 25 MHz reference clock
  always #20 clk = ~clk;
  plrc_pll_ctrl uut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .pllReset(pllReset),
    .fractionalStrap(fractionalStrap), .fbIn(fbIn), .fbOut(fbOut), .fbOutEn(fbOutEn),
    .outClk(outClk), .lvdsCaptureClk(lvdsCaptureClk), .externalClockOut(externalClockOut),
    .compensatedMask(compensatedMask), .locked(locked));
  plrc_core_model core (.clk(clk), .holdReset(holdReset), .pulseOnLoss(pulseOnLoss),
    .locked(locked), .fbOut(fbOut), .fbOutEn(fbOutEn), .pllReset(pllReset), .fbIn(fbIn),
    .downstreamRun(downstreamRun));
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // One gap cycle between strobes keeps each strobe a clean single pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e & m);
    mskQ.push_back(m);
    @(posedge clk);
    regRead <= 1'b0;
  endtask
  // Lock takes tens of cycles; the bound is generous but finite
  task automatic waitLock(input logic want);
    int n = 0;
    while (locked !== want && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("locked", 32'(want), 32'(locked));
  endtask
  // Read data stands only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clk) rdPend <= regRead;
  always @(negedge clk) begin
    if (rdPend) begin
      check("regRdData", expQ.pop_front(), regRdData & mskQ.pop_front());
    end
  end
  // Hang guard well above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(48));
    regAddr = 8'h00;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    fractionalStrap = 1'b0;
    holdReset = 1'b0;
    pulseOnLoss = 1'b0;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], vals[i], 32'hffffffff);
    waitLock(1'b1);
    rd(8'h18, 32'h31, 32'h7f);
    // Loop reset held by core logic
    @(posedge clk);
    holdReset <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check("locked", 32'h0, 32'(locked));
    check("outClk", 32'h0, 32'(outClk));
    rd(8'h18, 32'h0, 32'hf71);
    holdReset <= 1'b0;
    waitLock(1'b1);
    // Every feedback mode, then a refused code
    for (int m = 0; m < 6; m++) begin
      wr(8'h04, 32'(m));
      rd(8'h04, 32'(m), 32'h7);
      repeat (60) @(posedge clk);
      #1;
      check("fbOutEn", 32'(m > 3), 32'(fbOutEn));
    end
    wr(8'h04, 32'(6 + $urandom % 2));
    rd(8'h04, 32'h5, 32'h7);
    rd(8'h18, 32'h4, 32'h4);
    wr(8'h18, 32'h4);
    rd(8'h18, 32'h0, 32'h4);
    // Normal mode fed back through the second output counter
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h6);
    rd(8'h00, 32'h6, 32'h7);
    waitLock(1'b1);
    check("compensatedMask", 32'h2, 32'(compensatedMask));
    wr(8'h04, 32'h0);
    // A mode switch may cost lock a verdict later, so let it show before waiting
    repeat (12) @(posedge clk);
    waitLock(1'b1);
    // Lost lock with self-reset enabled
    wr(8'h00, 32'h1);
    wr(8'h08, 32'h5);
    waitLock(1'b0);
    rd(8'h18, 32'h42, 32'h72);
    wr(8'h08, 32'h4);
    waitLock(1'b1);
    // Lost lock recovered by the core's reset pulse
    wr(8'h00, 32'h0);
    pulseOnLoss <= 1'b1;
    wr(8'h08, 32'h6);
    waitLock(1'b0);
    wr(8'h08, 32'h4);
    waitLock(1'b1);
    // Fractional variant accepts direct mode only
    @(posedge clk);
    sys_rst <= 1'b1;
    fractionalStrap <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    wr(8'h04, 32'(1 + $urandom % 5));
    rd(8'h04, 32'h0, 32'h7);
    rd(8'h18, 32'hc, 32'hc);
    waitLock(1'b1);
    repeat (40) @(posedge clk);
    print_verdict();
  end
endmodule // plrc_pll_ctrl_tb
